// ==== common/dkrt_cfg.svh ====
// Timing and reset constants for the dual key reset timer.
// Assumes a 100 MHz system clock; all times are given in microseconds.
`ifndef DKRT_CFG_SVH
`define DKRT_CFG_SVH

// ==========================================================
// Clock
`define DKRT_CYC_PER_US     100

// ==========================================================
// Delay and release times in microseconds
`define DKRT_T_DLY_SHORT_US 7500000
`define DKRT_T_DLY_LONG_US  11250000
`define DKRT_T_REL_A_US     234000
`define DKRT_T_DLY_B_US     10000000
`define DKRT_T_REL_B_US     313000
`define DKRT_T_DLY_C_US     10000000
`define DKRT_T_REL_C_US     78000
`define DKRT_T_DLY_D_US     3000000
`define DKRT_T_REL_D_US     187500

// Microseconds to cycles; the largest figure stays below 2**31
`define DKRT_US2CYC(us)     ((us) * `DKRT_CYC_PER_US)

// ==========================================================
// Reset and counter load values
`define DKRT_CNT_ZERO       32'h0000_0000
`define DKRT_CNT_ONE        32'h0000_0001
`define DKRT_PIN_IDLE       2'h3
`define DKRT_STRAP_IDLE     3'h0

`endif

// ==== common/dkrt_pkg.sv ====
// Types shared by the dual key reset timer.
// Assumes nothing of its surroundings.
package dkrt_pkg;

   // =======================================================
   // Timer state, one-hot
   typedef enum logic [3:0] {
      DKRT_IDLE   = 4'h1,
      DKRT_COUNT  = 4'h2,
      DKRT_ASSERT = 4'h4,
      DKRT_REARM  = 4'h8
   } dkrt_state_t;

   typedef logic [31:0] dkrt_cnt_t;

endpackage : dkrt_pkg

// ==== rtl/dkrt_top.sv ====
// Dual key reset timer: two active-low key requests, long hold, reset out.
// Assumes key, select and test pins are asynchronous board-level levels
// and that the open-drain wire level is resolved outside this module.
//
// What this block does
// [RULE_01] Reset is asserted only after both keys stay low for the delay.
// [RULE_02] Selectable variant: select low gives 7.5 s, select high 11.25 s.
// [RULE_03] Selectable variant holds reset until either key returns high.
// [RULE_04] Fixed variants release reset after the release time elapses.
// [RULE_05] Fixed variants also release early when either key goes high.
// [RULE_06] Fixed options: 7.5/0.234, 10/0.313, 10/0.078, 3/0.1875 s.
// [RULE_07] Delay and release stay within ten percent of nominal.
// [RULE_08] Main reset is active-low open drain, pulling low only in reset.
// [RULE_09] Push-pull variants also drive an active-high reset output.
// [RULE_10] An unused key input is tied low by the system.
// [RULE_11] The delay select input is tied firmly high or low.
// [RULE_12] Factory test inputs are held low in normal use.
// [RULE_13] A key release during the delay abandons the count without reset.
// [RULE_14] After auto release both keys must be released and pressed again; here the release of either key rearms.
`timescale 1ns/10ps
`include "dkrt_cfg.svh"

module dkrt_top #(
   parameter bit        P_SELECTABLE   = 1'b0,
   parameter bit        P_PUSH_PULL    = 1'b1,
   parameter logic [31:0] P_DLY_CYC    =
      32'(`DKRT_US2CYC(`DKRT_T_DLY_SHORT_US)),
   parameter logic [31:0] P_DLY_LONG_CYC =
      32'(`DKRT_US2CYC(`DKRT_T_DLY_LONG_US)),
   parameter logic [31:0] P_REL_CYC    =
      32'(`DKRT_US2CYC(`DKRT_T_REL_A_US))
) (
   // Clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_sys_rst,
   // Key requests, active low, asynchronous
   input  wire logic i_key_request_a_n,
   input  wire logic i_key_request_b_n,
   // Straps, asynchronous
   input  wire logic i_delay_sel,
   input  wire logic i_factory_test_a,
   input  wire logic i_factory_test_b,
   // Open-drain reset, active low
   output logic      o_reset_od_out,
   output logic      o_reset_od_oe,
   // Push-pull reset, active high
   output logic      o_reset_out_push_pull_high
);

   // =======================================================
   // Input synchronisers
   // Two flops per pin; only the second stage is read.
   logic [1:0] key_s1_r;
   logic [1:0] key_s2_r;
   logic [2:0] strap_s1_r;
   logic [2:0] strap_s2_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         key_s1_r   <= `DKRT_PIN_IDLE;
         key_s2_r   <= `DKRT_PIN_IDLE;
         strap_s1_r <= `DKRT_STRAP_IDLE;
         strap_s2_r <= `DKRT_STRAP_IDLE;
      end else begin
         key_s1_r   <= {i_key_request_b_n, i_key_request_a_n};
         key_s2_r   <= key_s1_r;
         strap_s1_r <= {i_factory_test_b, i_factory_test_a, i_delay_sel};
         strap_s2_r <= strap_s1_r;
      end
   end

   // Both keys pressed together; test mode keeps the timer parked.
   // An unused key tied low leaves the other in sole control. [RULE_10]
   logic both_low;
   logic test_mode;
   assign test_mode = strap_s2_r[1] | strap_s2_r[2];           // [RULE_12]
   assign both_low  = (key_s2_r == 2'h0) & ~test_mode;

   // =======================================================
   // Timer state machine
   dkrt_pkg::dkrt_state_t state_r;
   dkrt_pkg::dkrt_state_t state_nxt;
   dkrt_pkg::dkrt_cnt_t   cnt_r;
   dkrt_pkg::dkrt_cnt_t   cnt_nxt;
   dkrt_pkg::dkrt_cnt_t   dly_lim_r;
   dkrt_pkg::dkrt_cnt_t   dly_lim_nxt;
   logic                  od_oe_r;
   logic                  od_oe_nxt;
   logic                  pp_r;
   logic                  pp_nxt;

   // Next state, counter and outputs
   // Exact cycle counts land well inside the ten percent band. [RULE_07]
   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      dly_lim_nxt = dly_lim_r;
      case (state_r)
         dkrt_pkg::DKRT_IDLE: begin
            cnt_nxt = `DKRT_CNT_ZERO;
            if (both_low) begin
               state_nxt = dkrt_pkg::DKRT_COUNT;
               // Strap read at the start of each hold   [RULE_02]
               if (P_SELECTABLE && strap_s2_r[0]) begin
                  dly_lim_nxt = P_DLY_LONG_CYC;
               end else begin
                  dly_lim_nxt = P_DLY_CYC;                  // [RULE_06]
               end
               cnt_nxt = `DKRT_CNT_ONE;
            end
         end
         dkrt_pkg::DKRT_COUNT: begin
            if (!both_low) begin
               // Abandon without reset; restart from zero [RULE_13]
               state_nxt = dkrt_pkg::DKRT_IDLE;
               cnt_nxt   = `DKRT_CNT_ZERO;
            end else if (cnt_r >= dly_lim_r) begin
               state_nxt = dkrt_pkg::DKRT_ASSERT;           // [RULE_01]
               cnt_nxt   = `DKRT_CNT_ONE;
            end else begin
               cnt_nxt = cnt_r + 32'h0000_0001;
            end
         end
         dkrt_pkg::DKRT_ASSERT: begin
            if (!both_low) begin
               // Key release ends reset in every variant [RULE_03] [RULE_05]
               state_nxt = dkrt_pkg::DKRT_IDLE;
               cnt_nxt   = `DKRT_CNT_ZERO;
            end else if (!P_SELECTABLE && cnt_r >= P_REL_CYC) begin
               state_nxt = dkrt_pkg::DKRT_REARM;            // [RULE_04]
               cnt_nxt   = `DKRT_CNT_ZERO;
            end else if (!P_SELECTABLE) begin
               cnt_nxt = cnt_r + 32'h0000_0001;
            end
         end
         dkrt_pkg::DKRT_REARM: begin
            // Needs a release before a new hold counts [RULE_14]
            if (!both_low) begin
               state_nxt = dkrt_pkg::DKRT_IDLE;
            end
         end
         default: begin
            state_nxt = dkrt_pkg::DKRT_IDLE;
            cnt_nxt   = `DKRT_CNT_ZERO;
         end
      endcase
      // Outputs follow the next state, so they change with it
      od_oe_nxt = (state_nxt == dkrt_pkg::DKRT_ASSERT);       // [RULE_08]
      pp_nxt    = P_PUSH_PULL && od_oe_nxt;                  // [RULE_09]
   end

   // State registers
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state_r   <= dkrt_pkg::DKRT_IDLE;
         cnt_r     <= `DKRT_CNT_ZERO;
         dly_lim_r <= P_DLY_CYC;
         od_oe_r   <= 1'b0;
         pp_r      <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         dly_lim_r <= dly_lim_nxt;
         od_oe_r   <= od_oe_nxt;
         pp_r      <= pp_nxt;
      end
   end

   // =======================================================
   // Outputs
   // The open-drain level is always low; only the enable moves.
   assign o_reset_od_out             = 1'b0;                 // [RULE_08]
   assign o_reset_od_oe              = od_oe_r;
   assign o_reset_out_push_pull_high = pp_r;

   // =======================================================
   // Checks
   a_assert_after_hold: assert property ( // [RULE_01]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(o_reset_od_oe) |->
         $past(state_r) == dkrt_pkg::DKRT_COUNT &&
         $past(cnt_r) >= $past(dly_lim_r) && $past(both_low))
      else $error("reset asserted without a full hold");

   a_delay_pick: assert property ( // [RULE_02]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      state_r == dkrt_pkg::DKRT_COUNT |->
         dly_lim_r == ((P_SELECTABLE && $past(strap_s2_r[0]) &&
            $past(state_r) == dkrt_pkg::DKRT_IDLE) ? P_DLY_LONG_CYC :
            ($past(state_r) == dkrt_pkg::DKRT_IDLE ? P_DLY_CYC :
             $past(dly_lim_r))))
      else $error("wrong delay limit chosen");

   a_sel_hold: assert property ( // [RULE_03]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      P_SELECTABLE && o_reset_od_oe && both_low |=> o_reset_od_oe)
      else $error("selectable reset dropped while keys held");

   a_auto_release: assert property ( // [RULE_04]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      !P_SELECTABLE && state_r == dkrt_pkg::DKRT_ASSERT &&
         cnt_r >= P_REL_CYC && both_low
         |=> !o_reset_od_oe && state_r == dkrt_pkg::DKRT_REARM)
      else $error("reset not released after release time");

   a_key_release: assert property ( // [RULE_05]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_reset_od_oe && !both_low |=> !o_reset_od_oe ##1 !o_reset_od_oe)
      else $error("reset held after key release");

   a_count_abort: assert property ( // [RULE_13]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      state_r == dkrt_pkg::DKRT_COUNT && !both_low
         |=> state_r == dkrt_pkg::DKRT_IDLE && cnt_r == `DKRT_CNT_ZERO
             && !o_reset_od_oe)
      else $error("count not abandoned");

   a_rearm_wait: assert property ( // [RULE_14]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      state_r == dkrt_pkg::DKRT_REARM && both_low
         |=> state_r == dkrt_pkg::DKRT_REARM && !o_reset_od_oe)
      else $error("rearmed without key release");

   a_od_follow: assert property ( // [RULE_08]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_reset_od_oe == (state_r == dkrt_pkg::DKRT_ASSERT) &&
         o_reset_od_out == 1'b0)
      else $error("open drain not tied to reset state");

   a_pp_high: assert property ( // [RULE_09]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_reset_out_push_pull_high == (P_PUSH_PULL && o_reset_od_oe))
      else $error("push-pull reset disagrees");

   a_release_bound: assert property ( // [RULE_07]
      @(posedge i_sys_clk) disable iff (i_sys_rst)
      state_r == dkrt_pkg::DKRT_ASSERT && !P_SELECTABLE
         |-> cnt_r <= P_REL_CYC && cnt_r != `DKRT_CNT_ZERO)
      else $error("release counter out of range");

endmodule : dkrt_top

// ==== testbench/dkrt_key_model.sv ====
// Model of the keys, straps and board pull-up around the reset timer.
// Assumes the bench changes its commands at the falling clock edge.
`timescale 1ns/10ps

module dkrt_key_model (
   // Commands from the bench
   input  wire logic i_press_a,
   input  wire logic i_press_b,
   input  wire logic i_single,
   input  wire logic i_long,
   input  wire logic i_test,
   // Open-drain reset from the timer
   input  wire logic i_od_out,
   input  wire logic i_od_oe,
   // Pins toward the timer and the system
   output logic      o_key_a_n,
   output logic      o_key_b_n,
   output logic      o_delay_sel,
   output logic      o_factory_test,
   output logic      o_sys_reset_n
);
   // ==========================================================
   // Keys pull low while pressed; an unused key is grounded
   assign o_key_a_n      = ~i_press_a;
   assign o_key_b_n      = i_single ? 1'b0 : ~i_press_b;
   // Straps always driven firmly, test low unless parking on purpose
   assign o_delay_sel    = i_long;
   assign o_factory_test = i_test;
   // Pull-up owns the wire whenever the timer lets go
   assign o_sys_reset_n  = i_od_oe ? i_od_out : 1'b1;
endmodule : dkrt_key_model

// ==== testbench/tb_dkrt_top.sv ====
// Self-checking bench: fixed and selectable timers share one key model.
// Assumes shortened counts of 20, 30 and 10 cycles in place of seconds.
`timescale 1ns/10ps

module tb_dkrt_top;
   localparam int D = 20, DL = 30, R = 10;
   typedef struct {bit lng; bit single; int hold; int rf; int rs;} dkrt_row_t;
   logic clk = 0, rst = 1, pa = 0, pb = 0, single = 0, lng = 0, tst = 0;
   logic ka_n, kb_n, sel, ftst, sys_n, odo_f, oe_f, pp_f, odo_s, oe_s, pp_s;
   int   mismatches = 0, cmp_count = 0, rf, rs, wf, ws, nf, ns;
   // Plain rows; the short hold twice in a row proves the count restarts
   dkrt_row_t rows[6] = '{'{0, 0, 40, D, D}, '{1, 0, 40, D, DL},
      '{0, 0, 18, 0, 0}, '{0, 0, 18, 0, 0}, '{0, 0, 26, D, D},
      '{0, 1, 40, D, D}};

   always #5 clk = ~clk;

   dkrt_key_model i_dkrt_key_model (.i_press_a(pa), .i_press_b(pb),
      .i_single(single), .i_long(lng), .i_test(tst), .i_od_out(odo_f),
      .i_od_oe(oe_f), .o_key_a_n(ka_n), .o_key_b_n(kb_n),
      .o_delay_sel(sel), .o_factory_test(ftst), .o_sys_reset_n(sys_n));
   dkrt_top #(.P_SELECTABLE(1'b0), .P_DLY_CYC(32'(D)), .P_REL_CYC(32'(R)))
   i_dkrt_top (.i_sys_clk(clk), .i_sys_rst(rst), .i_key_request_a_n(ka_n),
      .i_key_request_b_n(kb_n), .i_delay_sel(sel), .i_factory_test_a(ftst),
      .i_factory_test_b(1'b0), .o_reset_od_out(odo_f),
      .o_reset_od_oe(oe_f), .o_reset_out_push_pull_high(pp_f));
   dkrt_top #(.P_SELECTABLE(1'b1), .P_DLY_CYC(32'(D)),
      .P_DLY_LONG_CYC(32'(DL)), .P_REL_CYC(32'(R)))
   i_dkrt_top_sel (.i_sys_clk(clk), .i_sys_rst(rst),
      .i_key_request_a_n(ka_n), .i_key_request_b_n(kb_n),
      .i_delay_sel(sel), .i_factory_test_a(1'b0), .i_factory_test_b(ftst),
      .o_reset_od_out(odo_s), .o_reset_od_oe(oe_s),
      .o_reset_out_push_pull_high(pp_s));

   // ==========================================================
   // Compare helpers and the single exit
   task automatic report_and_stop;
      if (mismatches == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   task automatic chk_range(input int v, lo, hi, input string what);
      cmp_count++;
      if (v < lo || v > hi) begin
         mismatches++;
         $display("MISMATCH %0t %s got %0d", $time, what, v);
      end
   endtask : chk_range

   task automatic chk_bit(input logic v, e, input string what);
      cmp_count++;
      if (v !== e) begin
         mismatches++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask : chk_bit

   function automatic int mn(input int a, b);
      return (a < b) ? a : b;
   endfunction : mn

   // Hold the keys, release, then watch eight more cycles of settling
   task automatic run(input int hold);
      logic pf, ps;
      pf = 0;
      ps = 0;
      rf = 0;
      rs = 0;
      wf = 0;
      ws = 0;
      nf = 0;
      ns = 0;
      @(negedge clk);
      pa = 1;
      pb = !single;
      for (int i = 1; i <= hold + 8; i++) begin
         @(negedge clk);
         if (i == hold) {pa, pb} = 2'h0;
         if (oe_f === 1'b1) begin
            wf++;
            if (!pf) begin
               nf++;
               rf = (rf == 0) ? i : rf;
            end
         end
         if (oe_s === 1'b1) begin
            ws++;
            if (!ps) begin
               ns++;
               rs = (rs == 0) ? i : rs;
            end
         end
         pf = oe_f;
         ps = oe_s;
      end
   endtask : run

   // Output polarity and wire level, every cycle
   always @(negedge clk) begin
      chk_bit(pp_f, oe_f, "push-pull fixed");
      chk_bit(pp_s, oe_s, "push-pull select");
      chk_bit(sys_n, ~oe_f, "open-drain wire");
      chk_bit(oe_s & odo_s, 1'b0, "open-drain level");
   end

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #50us;
      mismatches++;
      report_and_stop();
   end

   initial begin
      repeat (5) @(negedge clk);
      rst = 0;
      chk_bit(oe_f | oe_s, 1'b0, "idle after reset");
      foreach (rows[k]) begin
         lng = rows[k].lng;
         single = rows[k].single;
         run(rows[k].hold);
         chk_range(rf, rows[k].rf ? D + 2 : 0, rows[k].rf ? D + 3 : 0,
            "fixed rise");
         chk_range(rs, rows[k].rs ? rows[k].rs + 2 : 0,
            rows[k].rs ? rows[k].rs + 3 : 0, "select rise");
         chk_range(wf, rows[k].rf ? mn(R, rows[k].hold - D - 2) : 0,
            rows[k].rf ? mn(R, rows[k].hold - D + 2) : 0,
            "fixed width");
         chk_range(ws, rows[k].rs ? rows[k].hold - rows[k].rs - 2 : 0,
            rows[k].rs ? rows[k].hold - rows[k].rs + 2 : 0,
            "select width");
         chk_range(nf + ns, 0, (rows[k].rf != 0) + (rows[k].rs != 0),
            "extra rise");
      end
      single = 0;
      lng = 0;
      // Test strap raised parks the timer, no reset on a long hold
      tst = 1;
      run(40);
      chk_range(nf + ns, 0, 0, "parked rise");
      tst = 0;
      // Reset in mid-assert clears both outputs at once
      {pa, pb} = 2'h3;
      for (int i = 0; i < 40 && oe_f !== 1'b1; i++) @(negedge clk);
      chk_bit(oe_f & oe_s, 1'b1, "held before reset");
      rst = 1;
      @(negedge clk);
      chk_bit(oe_f | oe_s, 1'b0, "reset clears oe");
      chk_bit(pp_f | pp_s, 1'b0, "reset clears pp");
      {pa, pb} = 2'h0;
      repeat (3) @(negedge clk);
      rst = 0;
      repeat (5) @(negedge clk);
      report_and_stop();
   end
endmodule : tb_dkrt_top
